// ==== rtl/flash_volatile_config_regs.sv ====
// Serial front end and configuration registers of the flash device.
`timescale 1ns/10ps
`default_nettype none
module flash_volatile_config_regs
  import flash_cfg_pkg::*;
#(
  parameter logic [3:0] DEFAULT_LATENCY = 4'h8
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Serial bus pins.
  input  wire logic        spiClk,
  input  wire logic        spiCsN,
  input  wire logic        spiDataIn,
  output logic             spiDataOut,
  output logic             spiDataOe,
  // Memory array port and segment select.
  input  wire logic [1:0]  extAddr,
  input  wire logic [7:0]  memData,
  output logic [31:0]      memAddr,
  output logic             memRead,
  // Behaviour register outputs and the tuning-pattern strobe.
  output logic             addrFourByte,
  output logic             quadProtocol,
  output logic             dualProtocol,
  output logic             singleRateTransfer,
  output logic [3:0]       latencyCycles,
  output logic             executeInPlaceEnable,
  output logic [1:0]       wrapMode,
  output logic             latchTuningPattern
);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [2:0] clkSync;
  logic [2:0] csSync;
  logic [2:0] dinSync;
  logic       clkLvl;
  logic       csLvl;
  logic       dinLvl;
  logic       riseEv;
  logic       fallEv;
  logic       csFall;
  logic       csRise;
  logic       dinNow;

  // Three stages per pin; a level counts once the last two stages agree.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clkSync <= 3'h0;
      csSync  <= 3'h7;
      dinSync <= 3'h0;
      clkLvl  <= 1'b0;
      csLvl   <= 1'b1;
      dinLvl  <= 1'b0;
    end else begin
      clkSync <= {clkSync[1:0], spiClk};
      csSync  <= {csSync[1:0], spiCsN};
      dinSync <= {dinSync[1:0], spiDataIn};
      if (clkSync[2] == clkSync[1]) clkLvl <= clkSync[2];
      if (csSync[2] == csSync[1]) csLvl <= csSync[2];
      if (dinSync[2] == dinSync[1]) dinLvl <= dinSync[2];
    end
  end

  // Edges are seen in the cycle the agreed level first differs.
  assign riseEv = (clkSync[2] == clkSync[1]) && clkSync[2] && !clkLvl;
  assign fallEv = (clkSync[2] == clkSync[1]) && !clkSync[2] && clkLvl;
  assign csFall = (csSync[2] == csSync[1]) && !csSync[2] && csLvl;
  assign csRise = (csSync[2] == csSync[1]) && csSync[2] && !csLvl;
  assign dinNow = (dinSync[2] == dinSync[1]) ? dinSync[2] : dinLvl;

  ////////////////////////////////////////////////////////////////////////////
  // Stored registers and the behaviour register.

  logic [15:0] nvReg;
  logic [7:0]  volReg;
  logic        loadNv;
  logic        volHit;

  // The power-on copy lands in the first cycle after reset release.
  always_ff @(posedge core_clk) begin
    if (sys_rst) loadNv <= 1'b1;
    else loadNv <= 1'b0;
  end

  // Behaviour register; only reset, the power-on copy and completed frames change it.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      addrFourByte         <= 1'b0;
      quadProtocol         <= 1'b0;
      dualProtocol         <= 1'b0;
      singleRateTransfer   <= 1'b1;
      latencyCycles        <= DEFAULT_LATENCY;
      executeInPlaceEnable <= 1'b0;
      wrapMode             <= 2'b11;
    end else if (loadNv) begin
      addrFourByte <= !nvReg[NV_ADDR_BIT];
      quadProtocol <= !nvReg[NV_QUAD_BIT] && !nvReg[NV_DUAL_BIT];
      dualProtocol <= nvReg[NV_QUAD_BIT] && !nvReg[NV_DUAL_BIT];
      singleRateTransfer <= nvReg[NV_RATE_BIT];
      latencyCycles <= latCount(nvReg[NV_LAT_LSB +: 4], DEFAULT_LATENCY);
      executeInPlaceEnable <= nvReg[NV_EXE_LSB +: 3] != 3'b111;
      wrapMode <= 2'b11;
    end else if (csRise && volHit) begin
      latencyCycles <= latCount(volReg[VOL_LAT_LSB +: 4],
                                DEFAULT_LATENCY);
      executeInPlaceEnable <= !volReg[VOL_EXE_BIT];
      wrapMode <= volReg[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine: command, address, latency, data.

  frame_state_t state;
  logic [7:0]   cmdReg;
  logic [5:0]   bitCnt;
  logic [31:0]  shReg;
  logic [31:0]  shNext;
  logic [7:0]   nvLow;
  logic [7:0]   curByte;
  logic [2:0]   outCnt;
  logic [1:0]   srcSel;
  logic         nvPhase;
  logic         fetch;
  logic [5:0]   addrLast;

  assign shNext   = {shReg[30:0], dinNow};
  assign addrLast = addrFourByte ? ADDR4_LAST : ADDR3_LAST;
  // A byte fetch from the array: at the latency end or a byte boundary.
  assign fetch = !csRise && !csFall && srcSel == 2'd2 &&
                 ((riseEv && state == ST_LAT &&
                   bitCnt == {2'b00, latencyCycles - 4'h1}) ||
                  (fallEv && state == ST_OUT && outCnt == 3'h7));

  // One process owns every frame register, so both edges share it.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state   <= ST_IDLE;
      cmdReg  <= 8'h00;
      bitCnt  <= 6'h00;
      shReg   <= 32'h0;
      nvReg   <= NV_RESET;
      volReg  <= VOL_RESET;
      nvLow   <= 8'h00;
      curByte <= 8'h00;
      outCnt  <= 3'h0;
      srcSel  <= 2'd0;
      nvPhase <= 1'b0;
      volHit  <= 1'b0;
      memAddr <= 32'h0;
    end else if (csRise) begin
      state <= ST_IDLE;
      volHit <= 1'b0;
    end else if (csFall) begin
      state  <= ST_CMD;
      bitCnt <= 6'h00;
      outCnt <= 3'h0;
      volHit <= 1'b0;
    end else if (riseEv && state != ST_IDLE && state != ST_OUT) begin
      shReg  <= shNext;
      bitCnt <= bitCnt + 6'h01;
      case (state)
        ST_CMD: begin
          if (bitCnt == BYTE_LAST) begin
            cmdReg <= shNext[7:0];
            bitCnt <= 6'h00;
            if (shNext[7:0] == CMD_RD_VOL) begin
              state   <= ST_OUT;
              srcSel  <= 2'd0;
              curByte <= volReg;
              volHit  <= 1'b1;
            end else if (shNext[7:0] == CMD_RD_NV) begin
              state   <= ST_OUT;
              srcSel  <= 2'd1;
              nvPhase <= 1'b1;
              curByte <= nvReg[7:0];
            end else if (shNext[7:0] == CMD_WR_VOL ||
                         shNext[7:0] == CMD_WR_NV) begin
              state <= ST_WR;
            end else if (shNext[7:0] == CMD_READ) begin
              state  <= ST_ADDR;
              srcSel <= 2'd2;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR: begin
          if (bitCnt == addrLast) begin
            state  <= ST_LAT;
            bitCnt <= 6'h00;
            if (addrFourByte) memAddr <= shNext;
            else memAddr <= {6'h00, extAddr, shNext[23:0]};
          end
        end
        ST_LAT: begin
          if (bitCnt == {2'b00, latencyCycles - 4'h1}) begin
            state   <= ST_OUT;
            curByte <= memData;
            memAddr <= nextAddr(memAddr, wrapMode);
          end
        end
        ST_WR: begin
          if (cmdReg == CMD_WR_VOL && bitCnt == BYTE_LAST) begin
            // Reserved bit is forced low on every write.
            volReg <= shNext[7:0] & ~(8'h01 << VOL_RSV_BIT);
            volHit <= 1'b1;
            state  <= ST_IDLE;
          end else if (cmdReg == CMD_WR_NV && bitCnt == BYTE_LAST) begin
            nvLow <= shNext[7:0];
          end else if (cmdReg == CMD_WR_NV && bitCnt == HWORD_LAST) begin
            // Only a full low-then-high pair is stored; reset reloads NV_RESET, so it never reaches the outputs.
            nvReg <= {shNext[7:0], nvLow};
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end else if (fallEv && state == ST_OUT) begin
      outCnt <= outCnt + 3'h1;
      if (outCnt == 3'h7) begin
        case (srcSel)
          2'd0: curByte <= volReg;
          2'd1: begin
            curByte <= nvPhase ? nvReg[15:8] : nvReg[7:0];
            nvPhase <= !nvPhase;
          end
          default: begin
            curByte <= memData;
            memAddr <= nextAddr(memAddr, wrapMode);
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pin and status strobes.

  // Data changes on falling edges so the host samples a settled bit.
  always_ff @(posedge core_clk) begin
    if (sys_rst || csRise) begin
      spiDataOut <= 1'b0;
      spiDataOe  <= 1'b0;
      latchTuningPattern <= 1'b0;
    end else if (fallEv && state == ST_LAT) begin
      spiDataOut <= TUNE_PATTERN[~bitCnt[2:0]];
      spiDataOe  <= 1'b1;
      latchTuningPattern <= 1'b1;
    end else if (fallEv && state == ST_OUT) begin
      spiDataOut <= curByte[~outCnt];
      spiDataOe  <= 1'b1;
      latchTuningPattern <= 1'b0;
    end
  end

  // One-cycle strobe for each byte taken from the array.
  always_ff @(posedge core_clk) begin
    if (sys_rst) memRead <= 1'b0;
    else memRead <= fetch;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  addr_mode_a: assert property ($fell(loadNv) |->
    addrFourByte == !$past(nvReg[NV_ADDR_BIT]))
    else $error("address byte count not taken from power-on register");
  quad_mode_a: assert property ($fell(loadNv) |->
    quadProtocol == ($past(nvReg[3:2]) == 2'b00))
    else $error("four-line protocol select wrong");
  vol_commit_a: assert property (csRise && volHit |=>
    wrapMode == $past(volReg[1:0]) && $stable(volReg))
    else $error("volatile value not committed at frame end");
  latency_code_a: assert property (csRise && volHit |=>
    latencyCycles == latCount($past(volReg[7:4]), DEFAULT_LATENCY))
    else $error("latency count decoded wrongly");
  exec_ctrl_a: assert property (csRise && volHit |=>
    executeInPlaceEnable == !$past(volReg[VOL_EXE_BIT]))
    else $error("execute-in-place polarity wrong");
  wrap_block_a: assert property (fetch && wrapMode == 2'b00 |=>
    memAddr[31:4] == $past(memAddr[31:4]) &&
    memAddr[3:0] == $past(memAddr[3:0]) + 4'h1)
    else $error("16-byte wrap left its block");
  wrap_end_a: assert property (fetch && wrapMode == 2'b10 &&
    memAddr[5:0] == 6'h3F |=> memAddr[5:0] == 6'h00 &&
    memAddr[31:6] == $past(memAddr[31:6]))
    else $error("64-byte wrap did not restart at block start");
  seq_read_a: assert property (fetch && wrapMode == 2'b11 |=>
    memAddr == $past(memAddr) + 32'h1)
    else $error("continuous read did not advance");
  tune_out_a: assert property (fallEv && state == ST_LAT &&
    !csRise |=> latchTuningPattern && spiDataOe)
    else $error("tuning pattern not driven in latency");
  reset_load_a: assert property ($fell(sys_rst) |-> loadNv ##1 !loadNv)
    else $error("power-on copy missing after reset");
  ext_ignore_a: assert property (riseEv && !csRise && !csFall &&
    state == ST_ADDR && bitCnt == ADDR4_LAST && addrFourByte |=>
    memAddr == $past(shNext))
    else $error("extended segment used in four-byte mode");
  commit_wait_a: assert property (!csRise && !loadNv |=>
    $stable(latencyCycles))
    else $error("behaviour register changed mid frame");
  rsv_zero_a: assert property (volReg[VOL_RSV_BIT] == 1'b0)
    else $error("reserved volatile bit set");

  vol_write_c: cover property (state == ST_WR ##[1:200] csRise && volHit);
  wrap_read_c: cover property (fetch && wrapMode != 2'b11 ##[1:400] fetch);
  nv_read_c: cover property (state == ST_OUT && srcSel == 2'd1 && fallEv);

endmodule
`default_nettype wire

// ==== rtl/flash_cfg_pkg.sv ====
// Constants, commands and helpers for the flash configuration registers.
// How it works
// - Power-on bit 0 clear selects four address bytes, set selects three.
// - Power-on bits 3 and 2 both clear select the four-line protocol.
// - Dedicated commands read and write the volatile register, then copy it.
// - Volatile bits 7:4 give 1 to 14 latency cycles; 0 and 15 mean default.
// - Volatile bit 3 clear enables execute-in-place; set disables it.
// - Volatile bits 1:0 select a 16, 32 or 64 byte aligned wrap.
// - Wrapped output runs to the block end, then restarts at its first byte.
// - Wrap code 11 reads sequentially through the whole array.
// - A known pattern lets the host tune its sampling point.
// - Power-on register is copied into the behaviour register after reset.
// - Four-byte addressing ignores the extended segment register.
// - Volatile values take effect once their write command completes.
package flash_cfg_pkg;
  // Command codes.
  localparam logic [7:0] CMD_WR_VOL = 8'h81;
  localparam logic [7:0] CMD_RD_VOL = 8'h85;
  localparam logic [7:0] CMD_WR_NV  = 8'hB1;
  localparam logic [7:0] CMD_RD_NV  = 8'hB5;
  localparam logic [7:0] CMD_READ   = 8'h0B;
  // Values after reset.
  localparam logic [15:0] NV_RESET  = 16'hFFFF;
  localparam logic [7:0]  VOL_RESET = 8'hFB;
  // Field positions.
  localparam int NV_ADDR_BIT = 0;
  localparam int NV_DUAL_BIT = 2;
  localparam int NV_QUAD_BIT = 3;
  localparam int NV_RATE_BIT = 5;
  localparam int NV_EXE_LSB  = 9;
  localparam int NV_LAT_LSB  = 12;
  localparam int VOL_LAT_LSB = 4;
  localparam int VOL_EXE_BIT = 3;
  localparam int VOL_RSV_BIT = 2;
  // Bit counts of the serial phases.
  localparam logic [5:0] BYTE_LAST  = 6'h07;
  localparam logic [5:0] HWORD_LAST = 6'h0F;
  localparam logic [5:0] ADDR3_LAST = 6'h17;
  localparam logic [5:0] ADDR4_LAST = 6'h1F;
  // Fixed byte shifted out during latency cycles.
  localparam logic [7:0] TUNE_PATTERN = 8'h34;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_CMD = 3'b001, ST_ADDR = 3'b011,
    ST_LAT  = 3'b010, ST_OUT = 3'b110, ST_WR   = 3'b111
  } frame_state_t;

  // Latency count: codes 0 and 15 fall back to the command default.
  function automatic logic [3:0] latCount(input logic [3:0] code,
                                          input logic [3:0] dflt);
    return (code == 4'h0 || code == 4'hF) ? dflt : code;
  endfunction

  // Next read address for the given wrap code.
  function automatic logic [31:0] nextAddr(input logic [31:0] a,
                                           input logic [1:0] w);
    case (w)
      2'b00:   return {a[31:4], a[3:0] + 4'h1};
      2'b01:   return {a[31:5], a[4:0] + 5'h01};
      2'b10:   return {a[31:6], a[5:0] + 6'h01};
      default: return a + 32'h1;
    endcase
  endfunction
endpackage

// ==== verif/flash_host_model.sv ====
// Host-side serial controller model that drives the flash link in mode 0.
`timescale 1ns/10ps
`default_nettype none
module flash_host_model (
  // Clock.
  input  wire logic core_clk,
  // Serial bus pins.
  output logic      spiClk,
  output logic      spiCsN,
  output logic      spiDataIn,
  input  wire logic spiDataOut,
  input  wire logic spiDataOe
);
  // The link clock rests low and the select high between frames.
  initial begin
    spiClk    = 1'b0;
    spiCsN    = 1'b1;
    spiDataIn = 1'b0;
  end

  // Waits a number of falling edges of the core clock.
  task automatic waitFall(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Opens a frame with the link clock still low.
  task automatic frameStart();
    waitFall(1);
    spiCsN = 1'b1 ^ 1'b1;
    waitFall(4);
  endtask

  // Closes a frame; the data line then flips so a stale bit never lingers.
  task automatic frameEnd();
    waitFall(4);
    spiCsN    = 1'b1;
    spiDataIn = ~spiDataIn;
    waitFall(12);
  endtask

  // Shifts a byte out MSB first and samples the device line before each
  // fall, well after the device has settled its bit.
  // Half period of four core cycles keeps the link at 12.5 MHz.
  task automatic xfer(input logic [7:0] txByte, output logic [7:0] rxByte);
    for (int i = 7; i >= 0; i--) begin
      spiDataIn = txByte[i];
      waitFall(4);
      spiClk    = 1'b1;
      waitFall(3);
      // A released data line floats to its pull-up level.
      rxByte[i] = spiDataOe ? spiDataOut : 1'b1;
      waitFall(1);
      spiClk    = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking testbench for the flash configuration registers.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import flash_cfg_pkg::*;
  logic        core_clk, sys_rst, spiClk, spiCsN, spiDataIn;
  logic        spiDataOut, spiDataOe, memRead, addrFourByte;
  logic        quadProtocol, dualProtocol, singleRateTransfer;
  logic        executeInPlaceEnable, latchTuningPattern;
  logic [1:0]  extAddr, wrapMode;
  logic [3:0]  latencyCycles;
  logic [7:0]  memData, rxSeen, volVal;
  logic [31:0] memAddr;
  logic [23:0] startAddr;
  logic [7:0]  expQ[$];
  logic [3:0]  latCodes[5] = '{4'h0, 4'h1, 4'hE, 4'hF, 4'h8};
  int          miscompares, comparisons, blockSize, fetchCnt, tuneCnt;
  event        byteSeen;

  // Array contents depend on the segment bits so a wrong segment shows.
  function automatic logic [7:0] memByte(input logic [31:0] a);
    return a[7:0] ^ {a[25:24], a[13:8]};
  endfunction
  assign memData = memByte(memAddr);

  // Expected behaviour outputs after a volatile value is committed.
  function automatic logic [10:0] cfgExp(input logic [7:0] v);
    logic [3:0] lat;
    lat = (v[7:4] == 4'h0 || v[7:4] == 4'hF) ? 4'h8 : v[7:4];
    return {3'b000, 1'b1, lat, ~v[3], v[1:0]};
  endfunction

  // Expected next address; wrapping keeps the upper bits of the block.
  function automatic logic [31:0] nextExp(input logic [31:0] a,
                                          input logic [1:0] w);
    logic [31:0] m;
    m = (32'h10 << w) - 32'h1;
    return (w == 2'b11) ? a + 32'h1 : (a & ~m) | ((a + 32'h1) & m);
  endfunction

  flash_volatile_config_regs #(
    .DEFAULT_LATENCY(4'h8)
  ) u_flash_volatile_config_regs (
    .core_clk(core_clk), .sys_rst(sys_rst), .spiClk(spiClk),
    .spiCsN(spiCsN), .spiDataIn(spiDataIn), .spiDataOut(spiDataOut),
    .spiDataOe(spiDataOe), .extAddr(extAddr), .memData(memData),
    .memAddr(memAddr), .memRead(memRead), .addrFourByte(addrFourByte),
    .quadProtocol(quadProtocol), .dualProtocol(dualProtocol),
    .singleRateTransfer(singleRateTransfer), .latencyCycles(latencyCycles),
    .executeInPlaceEnable(executeInPlaceEnable), .wrapMode(wrapMode),
    .latchTuningPattern(latchTuningPattern));

  flash_host_model u_flash_host_model (
    .core_clk(core_clk), .spiClk(spiClk), .spiCsN(spiCsN),
    .spiDataIn(spiDataIn), .spiDataOut(spiDataOut),
    .spiDataOe(spiDataOe));

  // Free-running core clock.
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////
  // Compare tasks and the closing task.
  task automatic chkByte(input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] link byte expected %h seen %h", exp, got);
    end
  endtask
  task automatic chkCfg(input logic [10:0] exp);
    logic [10:0] got;
    got = {addrFourByte, quadProtocol, dualProtocol, singleRateTransfer,
           latencyCycles, executeInPlaceEnable, wrapMode};
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] config outputs expected %h seen %h", exp, got);
    end
  endtask
  task automatic chkCount(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      miscompares++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Link tasks; reads note their expectation before the byte arrives.
  task automatic wrByte(input logic [7:0] b);
    logic [7:0] rx;
    u_flash_host_model.xfer(b, rx);
  endtask
  task automatic rdByte(input logic [7:0] exp);
    logic [7:0] rx;
    expQ.push_back(exp);
    u_flash_host_model.xfer(8'($urandom), rx);
    rxSeen = rx;
    ->byteSeen;
  endtask
  task automatic wrCmd(input logic [7:0] c, input logic [7:0] d0,
                       input logic [7:0] d1, input int n);
    u_flash_host_model.frameStart();
    wrByte(c);
    wrByte(d0);
    if (n > 1) wrByte(d1);
    u_flash_host_model.frameEnd();
  endtask
  task automatic rdReg(input logic [7:0] c, input logic [7:0] e0,
                       input logic [7:0] e1);
    u_flash_host_model.frameStart();
    wrByte(c);
    rdByte(e0);
    rdByte(e1);
    u_flash_host_model.frameEnd();
  endtask
  // Read with eight latency clocks; the segment comes from extAddr.
  task automatic rdArray(input logic [23:0] a, input logic [1:0] w,
                         input int n);
    logic [31:0] ad;
    int          f0;
    int          t0;
    ad = {6'h00, extAddr, a};
    f0 = fetchCnt;
    t0 = tuneCnt;
    u_flash_host_model.frameStart();
    wrByte(CMD_READ);
    wrByte(a[23:16]);
    wrByte(a[15:8]);
    wrByte(a[7:0]);
    rdByte(TUNE_PATTERN);
    for (int i = 0; i < n; i++) begin
      rdByte(memByte(ad));
      ad = nextExp(ad, w);
    end
    u_flash_host_model.frameEnd();
    // The device always holds one byte ahead of the last byte taken.
    chkCount("array fetches", n + 1, fetchCnt - f0);
    // Eight dummy clocks of eight core cycles each show the pattern.
    chkCount("pattern cycles", 64, tuneCnt - t0);
  endtask

  // Fetch strobes and pattern cycles, counted where they are settled.
  always @(negedge core_clk) begin
    if (memRead === 1'b1) fetchCnt++;
    if (latchTuningPattern === 1'b1) tuneCnt++;
  end

  // Result watcher pairs each received byte with the oldest note.
  initial forever begin
    @(byteSeen);
    chkByte(expQ.pop_front(), rxSeen);
  end

  // Watchdog; the whole sequence needs about 13300 cycles.
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    miscompares = 0;
    comparisons = 0;
    fetchCnt    = 0;
    tuneCnt     = 0;
    sys_rst     = 1'b1;
    extAddr     = 2'b00;
    void'($urandom(48));
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    chkCfg(cfgExp(VOL_RESET));
    rdReg(CMD_RD_VOL, VOL_RESET, VOL_RESET);
    rdReg(CMD_RD_NV, NV_RESET[7:0], NV_RESET[15:8]);
    // Boundary and default latency codes, with the reserved bit forced.
    foreach (latCodes[i]) begin
      volVal = {latCodes[i], 4'($urandom)} | 8'h04;
      wrCmd(CMD_WR_VOL, volVal, 8'h00, 1);
      chkCfg(cfgExp(volVal));
      rdReg(CMD_RD_VOL, volVal & 8'hFB, volVal & 8'hFB);
    end
    // Every wrap code; codes 00 to 10 start two bytes before the block end, code 11 at FFFFFD.
    for (int w = 0; w < 4; w++) begin
      wrCmd(CMD_WR_VOL, {4'h8, 2'b10, 2'(w)}, 8'h00, 1);
      extAddr   = 2'($urandom);
      blockSize = 16 << w;
      startAddr = (24'($urandom) & ~24'(blockSize - 1)) | 24'(blockSize - 2);
      if (w == 3) startAddr = 24'hFFFFFD;
      rdArray(startAddr, 2'(w), (w == 3) ? 6 : blockSize + 3);
    end
    // A lone power-on byte is dropped; a full pair is stored but leaves the outputs alone.
    wrCmd(CMD_WR_NV, 8'h00, 8'h00, 1);
    rdReg(CMD_RD_NV, 8'hFF, 8'hFF);
    wrCmd(CMD_WR_NV, 8'hF2, 8'h3F, 2);
    rdReg(CMD_RD_NV, 8'hF2, 8'h3F);
    chkCfg(cfgExp({4'h8, 2'b10, 2'b11}));
    // Mid-run reset restores the behaviour register and volatile value.
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    chkCfg(cfgExp(VOL_RESET));
    rdReg(CMD_RD_VOL, VOL_RESET, VOL_RESET);
    summarize();
  end
endmodule
`default_nettype wire
